// File: hbfc_motor_model.sv
/*
  Motor winding and sense model for the full-bridge control block.
  Assumes leg gate outputs of hbfc_top; fault pin has an external pull-up.
*/
`timescale 1ns/100ps
module hbfc_motor_model #(
  parameter int LIMIT = 200,
  parameter int STEP = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] leg_hi_i,
  input wire logic [1:0] leg_lo_i,
  input wire logic fault_oe_i,
  input wire logic force_over_i,
  output logic sense_over_o,
  output logic fault_pin_o
);
  // ----------------------------------------------------------------
  // Winding current
  // ----------------------------------------------------------------
  int cur_reg;
  logic drive;

  // Current rises only with one leg high and the other low
  assign drive = (leg_hi_i == 2'h1 && leg_lo_i == 2'h2) || (leg_hi_i == 2'h2 && leg_lo_i == 2'h1);

  // Rise by STEP, decay by one; clamp keeps discharge long enough to drop below
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      cur_reg <= 0;
    else if (drive && cur_reg < LIMIT)
      cur_reg <= cur_reg + STEP;
    else if (!drive && cur_reg > 0)
      cur_reg <= cur_reg - 1;
  end

  // Forced level lets a scenario hold the comparator high
  assign sense_over_o = force_over_i || (cur_reg >= LIMIT);
  assign fault_pin_o = !fault_oe_i; // Pull-up wins when released
endmodule : hbfc_motor_model

// File: hbfc_pkg.sv
/*
  Constants shared by the full-bridge fault and chopper control block:
  register map, field positions, reset values, timing figures and state codes.
  Assumes a 20 MHz core clock and a 10 MHz reference oscillator.
*/
package hbfc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_PERIOD_NS = 50;
  localparam int OSC_PERIOD_NS = 100;
  localparam int OSC_PER_TICK = 4;
  localparam int DISCHARGE_TICKS = 39;
  localparam int DISCHARGE_CYCLES =
    (DISCHARGE_TICKS * OSC_PER_TICK * OSC_PERIOD_NS) / CORE_PERIOD_NS;
  localparam int MIN_CHARGE_NS = 1700;
  localparam int MIN_CHARGE_CYCLES = (MIN_CHARGE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int DEAD_TIME_NS = 500;
  localparam int DEAD_CYCLES = (DEAD_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  localparam int CNT_W = 24;
  localparam int PH_W = 9;
  localparam int DT_W = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STOP = 8'h04;
  localparam logic [7:0] ADDR_DETECT = 8'h08;
  localparam logic [7:0] ADDR_DEAD = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int CTRL_CHOP_EN_BIT = 0;
  localparam logic CTRL_CHOP_EN_RST = 1'b1;
  localparam logic [DT_W-1:0] DEAD_RST = DT_W'(DEAD_CYCLES);

  localparam int ST_STATE_LSB = 0;
  localparam int ST_PHASE_BIT = 4;
  localparam int ST_HI_LSB = 8;
  localparam int ST_LO_LSB = 10;
  localparam int ST_PIN_LSB = 16;

  // Synchronised pin vector positions
  localparam int PIN_SLEEP_N = 0;
  localparam int PIN_SEL_A = 1;
  localparam int PIN_SEL_B = 2;
  localparam int PIN_MOTOR_UV = 3;
  localparam int PIN_LOGIC_UV = 4;
  localparam int PIN_THERMAL = 5;
  localparam int PIN_OC_LSB = 6;
  localparam int PIN_STOP_GND = 10;
  localparam int PIN_SENSE = 11;
  localparam int PIN_FAULT = 12;
  localparam int PIN_W = 13;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HBFC_STANDBY = 3'b000,
    HBFC_RUN = 3'b001,
    HBFC_UVLO = 3'b010,
    HBFC_THERMAL = 3'b011,
    HBFC_OVERCUR = 3'b100
  } hbfc_fault_t;

  typedef enum logic [0:0] {
    HBFC_CHARGE = 1'b0,
    HBFC_DISCHARGE = 1'b1
  } hbfc_phase_t;

  typedef enum logic [1:0] {
    HBFC_LEG_OFF = 2'b00,
    HBFC_LEG_HIGH = 2'b01,
    HBFC_LEG_LOW = 2'b10
  } hbfc_leg_t;

endpackage : hbfc_pkg

// File: hbfc_top.sv
/*
  Full-bridge control logic: drive decode, dead time per leg, fault state
  machine (undervoltage, thermal, overcurrent, standby), peak-current chopper
  and an APB register slave.
  Assumes analog comparators deliver level indications on pins, asynchronous
  to core_clk_i, and that the output stage turns gate levels into leg states.
*/
`timescale 1ns/100ps
module hbfc_top #(
  parameter logic [hbfc_pkg::CNT_W-1:0] STOP_CYCLES_RST = 24'h00_4E20,
  parameter logic [hbfc_pkg::CNT_W-1:0] DETECT_CYCLES_RST = 24'h00_0028
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_select_low_n_i,
  input wire logic drive_select_a_i,
  input wire logic drive_select_b_i,
  input wire logic motor_supply_low_i,
  input wire logic logic_supply_low_i,
  input wire logic thermal_trip_i,
  input wire logic [3:0] overcurrent_i,
  input wire logic stop_pin_grounded_i,
  input wire logic sense_voltage_over_i,
  input wire logic fault_pin_i,
  output logic fault_o,
  output logic fault_oe_o,
  output logic [1:0] bridge_leg_hi_o,
  output logic [1:0] bridge_leg_lo_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [hbfc_pkg::PIN_W-1:0] pin_meta_reg;
  logic [hbfc_pkg::PIN_W-1:0] pin_reg;
  logic [hbfc_pkg::PIN_W-1:0] pin_raw;

  assign pin_raw = {fault_pin_i, sense_voltage_over_i, stop_pin_grounded_i, overcurrent_i,
                    thermal_trip_i, logic_supply_low_i, motor_supply_low_i,
                    drive_select_b_i, drive_select_a_i, sleep_select_low_n_i};

  // Two stages; only pin_reg is read by logic
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= '0;
      pin_reg <= '0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_reg <= pin_meta_reg;
    end
  end

  logic sleep_n;
  logic sel_a;
  logic sel_b;
  logic uv_any;
  logic hot;
  logic oc_any;
  logic stop_gnd;
  logic sense_over;

  assign sleep_n = pin_reg[hbfc_pkg::PIN_SLEEP_N];
  assign sel_a = pin_reg[hbfc_pkg::PIN_SEL_A];
  assign sel_b = pin_reg[hbfc_pkg::PIN_SEL_B];
  assign uv_any = pin_reg[hbfc_pkg::PIN_MOTOR_UV] | pin_reg[hbfc_pkg::PIN_LOGIC_UV];
  assign hot = pin_reg[hbfc_pkg::PIN_THERMAL];
  assign oc_any = |pin_reg[hbfc_pkg::PIN_OC_LSB +: 4];
  assign stop_gnd = pin_reg[hbfc_pkg::PIN_STOP_GND];
  assign sense_over = pin_reg[hbfc_pkg::PIN_SENSE];

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic chop_en_reg;
  logic [hbfc_pkg::CNT_W-1:0] stop_cycles_reg;
  logic [hbfc_pkg::CNT_W-1:0] detect_cycles_reg;
  logic [hbfc_pkg::DT_W-1:0] dead_cycles_reg;
  logic [31:0] status_word;
  logic [31:0] rdata_next;
  logic addr_hit;
  logic apb_write;

  hbfc_pkg::hbfc_fault_t fault_reg;
  hbfc_pkg::hbfc_phase_t phase_reg;

  always_comb begin
    status_word = '0;
    status_word[hbfc_pkg::ST_STATE_LSB +: 3] = fault_reg;
    status_word[hbfc_pkg::ST_PHASE_BIT] = phase_reg;
    status_word[hbfc_pkg::ST_HI_LSB +: 2] = bridge_leg_hi_o;
    status_word[hbfc_pkg::ST_LO_LSB +: 2] = bridge_leg_lo_o;
    status_word[hbfc_pkg::ST_PIN_LSB +: hbfc_pkg::PIN_W] = pin_reg;
  end

  // Address decode; unmapped offsets read zero and raise pslverr
  always_comb begin
    addr_hit = 1'b1;
    rdata_next = '0;
    case (paddr_i)
      hbfc_pkg::ADDR_CTRL: rdata_next[hbfc_pkg::CTRL_CHOP_EN_BIT] = chop_en_reg;
      hbfc_pkg::ADDR_STOP: rdata_next[hbfc_pkg::CNT_W-1:0] = stop_cycles_reg;
      hbfc_pkg::ADDR_DETECT: rdata_next[hbfc_pkg::CNT_W-1:0] = detect_cycles_reg;
      hbfc_pkg::ADDR_DEAD: rdata_next[hbfc_pkg::DT_W-1:0] = dead_cycles_reg;
      hbfc_pkg::ADDR_STATUS: rdata_next = status_word;
      default: addr_hit = 1'b0;
    endcase
  end

  // Answer is set up in the setup cycle so the access phase is always one cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_hit;
      prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rdata_next : 32'h0000_0000;
    end
  end

  assign apb_write = psel_i & penable_i & pready_o & pwrite_i;

  // Writable configuration; status is read-only
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chop_en_reg <= hbfc_pkg::CTRL_CHOP_EN_RST;
      stop_cycles_reg <= STOP_CYCLES_RST;
      detect_cycles_reg <= DETECT_CYCLES_RST;
      dead_cycles_reg <= hbfc_pkg::DEAD_RST;
    end else if (apb_write) begin
      case (paddr_i)
        hbfc_pkg::ADDR_CTRL: chop_en_reg <= pwdata_i[hbfc_pkg::CTRL_CHOP_EN_BIT];
        hbfc_pkg::ADDR_STOP: stop_cycles_reg <= pwdata_i[hbfc_pkg::CNT_W-1:0];
        hbfc_pkg::ADDR_DETECT: detect_cycles_reg <= pwdata_i[hbfc_pkg::CNT_W-1:0];
        hbfc_pkg::ADDR_DEAD: dead_cycles_reg <= pwdata_i[hbfc_pkg::DT_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault state machine
  // ----------------------------------------------------------------
  logic [hbfc_pkg::CNT_W-1:0] off_cnt_reg;
  logic [hbfc_pkg::CNT_W-1:0] oc_cnt_reg;
  logic stop_elapsed;

  // Outputs must stay off strictly longer than the programmed stop interval
  assign stop_elapsed = off_cnt_reg > stop_cycles_reg;

  // Overcurrent persistence counter; brief spikes below the detect count are ignored
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oc_cnt_reg <= '0;
    end else if (oc_any && fault_reg == hbfc_pkg::HBFC_RUN) begin
      if (oc_cnt_reg != {hbfc_pkg::CNT_W{1'b1}}) begin
        oc_cnt_reg <= oc_cnt_reg + 1'b1;
      end
    end else begin
      oc_cnt_reg <= '0;
    end
  end

  // Off-time counter runs while latched in a trip state, saturating
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      off_cnt_reg <= '0;
    end else if (fault_reg == hbfc_pkg::HBFC_THERMAL || fault_reg == hbfc_pkg::HBFC_OVERCUR) begin
      if (off_cnt_reg != {hbfc_pkg::CNT_W{1'b1}}) begin
        off_cnt_reg <= off_cnt_reg + 1'b1;
      end
    end else begin
      off_cnt_reg <= '0;
    end
  end

  // Priority: standby, undervoltage, thermal, overcurrent
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_reg <= hbfc_pkg::HBFC_STANDBY;
    end else if (!sleep_n) begin
      fault_reg <= hbfc_pkg::HBFC_STANDBY;
    end else begin
      case (fault_reg)
        hbfc_pkg::HBFC_STANDBY: fault_reg <= hbfc_pkg::HBFC_RUN;
        hbfc_pkg::HBFC_RUN: begin
          if (uv_any) begin
            fault_reg <= hbfc_pkg::HBFC_UVLO;
          end else if (hot) begin
            fault_reg <= hbfc_pkg::HBFC_THERMAL;
          end else if (oc_any && oc_cnt_reg >= detect_cycles_reg) begin
            fault_reg <= hbfc_pkg::HBFC_OVERCUR;
          end
        end
        hbfc_pkg::HBFC_UVLO: begin
          if (!uv_any) begin
            fault_reg <= hbfc_pkg::HBFC_RUN;
          end
        end
        hbfc_pkg::HBFC_THERMAL: begin
          if (!stop_gnd && !hot && stop_elapsed) begin
            fault_reg <= hbfc_pkg::HBFC_RUN;
          end
        end
        hbfc_pkg::HBFC_OVERCUR: begin
          if (!stop_gnd && stop_elapsed) begin
            fault_reg <= hbfc_pkg::HBFC_RUN;
          end
        end
        default: fault_reg <= hbfc_pkg::HBFC_STANDBY;
      endcase
    end
  end

  // Open-drain fault pin: pulled low only while running normally
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_oe_o <= 1'b0;
    end else begin
      // Live sleep, undervoltage and thermal pins also release, so a one-cycle pass through run never shows ok
      fault_oe_o <= (fault_reg == hbfc_pkg::HBFC_RUN) && sleep_n && !uv_any && !hot;
    end
  end

  assign fault_o = 1'b0;

  // ----------------------------------------------------------------
  // Peak-current chopper
  // ----------------------------------------------------------------
  logic running;
  logic driving;
  logic [hbfc_pkg::PH_W-1:0] phase_cnt_reg;

  // Gating on the live pins stops a leg firing for one cycle on the way into standby, undervoltage or thermal trip
  assign running = (fault_reg == hbfc_pkg::HBFC_RUN) && sleep_n && !uv_any && !hot;
  assign driving = running && chop_en_reg && (sel_a ^ sel_b);

  // Discharge ignores the comparator until its full count ends
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= hbfc_pkg::HBFC_CHARGE;
      phase_cnt_reg <= '0;
    end else if (!driving) begin
      phase_reg <= hbfc_pkg::HBFC_CHARGE;
      phase_cnt_reg <= '0;
    end else if (phase_reg == hbfc_pkg::HBFC_CHARGE) begin
      if (sense_over && phase_cnt_reg >= hbfc_pkg::PH_W'(hbfc_pkg::MIN_CHARGE_CYCLES - 1)) begin
        phase_reg <= hbfc_pkg::HBFC_DISCHARGE;
        phase_cnt_reg <= '0;
      end else if (phase_cnt_reg < hbfc_pkg::PH_W'(hbfc_pkg::MIN_CHARGE_CYCLES - 1)) begin
        phase_cnt_reg <= phase_cnt_reg + 1'b1;
      end
    end else if (phase_cnt_reg == hbfc_pkg::PH_W'(hbfc_pkg::DISCHARGE_CYCLES - 1)) begin
      phase_cnt_reg <= '0;
      phase_reg <= sense_over ? hbfc_pkg::HBFC_DISCHARGE : hbfc_pkg::HBFC_CHARGE;
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Drive decode
  // ----------------------------------------------------------------
  hbfc_pkg::hbfc_leg_t leg_req [2];

  // Select pins pass straight through, so host PWM alternates drive and brake
  always_comb begin
    leg_req[0] = hbfc_pkg::HBFC_LEG_OFF;
    leg_req[1] = hbfc_pkg::HBFC_LEG_OFF;
    if (!running) begin
      leg_req[0] = hbfc_pkg::HBFC_LEG_OFF;
      leg_req[1] = hbfc_pkg::HBFC_LEG_OFF;
    end else if (phase_reg == hbfc_pkg::HBFC_DISCHARGE) begin
      leg_req[0] = hbfc_pkg::HBFC_LEG_LOW;
      leg_req[1] = hbfc_pkg::HBFC_LEG_LOW;
    end else begin
      case ({sel_a, sel_b})
        2'b11: begin
          leg_req[0] = hbfc_pkg::HBFC_LEG_LOW;
          leg_req[1] = hbfc_pkg::HBFC_LEG_LOW;
        end
        2'b01: begin
          leg_req[0] = hbfc_pkg::HBFC_LEG_LOW;
          leg_req[1] = hbfc_pkg::HBFC_LEG_HIGH;
        end
        2'b10: begin
          leg_req[0] = hbfc_pkg::HBFC_LEG_HIGH;
          leg_req[1] = hbfc_pkg::HBFC_LEG_LOW;
        end
        default: begin
          leg_req[0] = hbfc_pkg::HBFC_LEG_OFF;
          leg_req[1] = hbfc_pkg::HBFC_LEG_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Dead time per leg
  // ----------------------------------------------------------------
  // Turn-off is immediate; turn-on waits until both gates have been off for
  // the dead count. This costs one dead interval whenever a leg changes from one gate to the other,
  // but never lets a stale gate overlap its partner.
  for (genvar g = 0; g < 2; g++) begin : g_leg
    logic [hbfc_pkg::DT_W-1:0] dead_cnt_reg;
    logic want_hi;
    logic want_lo;
    logic gates_off;

    assign want_hi = leg_req[g] == hbfc_pkg::HBFC_LEG_HIGH;
    assign want_lo = leg_req[g] == hbfc_pkg::HBFC_LEG_LOW;
    assign gates_off = !bridge_leg_hi_o[g] && !bridge_leg_lo_o[g];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        dead_cnt_reg <= '0;
      end else if (!gates_off) begin
        dead_cnt_reg <= '0;
      end else if (dead_cnt_reg != {hbfc_pkg::DT_W{1'b1}}) begin
        dead_cnt_reg <= dead_cnt_reg + 1'b1;
      end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        bridge_leg_hi_o[g] <= 1'b0;
        bridge_leg_lo_o[g] <= 1'b0;
      end else if ((bridge_leg_hi_o[g] && !want_hi) || (bridge_leg_lo_o[g] && !want_lo)) begin
        bridge_leg_hi_o[g] <= 1'b0;
        bridge_leg_lo_o[g] <= 1'b0;
      end else if (gates_off && dead_cnt_reg >= dead_cycles_reg) begin
        bridge_leg_hi_o[g] <= want_hi;
        bridge_leg_lo_o[g] <= want_lo;
      end
    end
  end

endmodule : hbfc_top

// File: hbfc_top_asserts.sv
/*
  Checker for the bridge control top: gate safety, dead time, APB answer, shutdown.
  Assumes it is bound to hbfc_top and sees only its ports.
*/
`timescale 1ns/100ps
module hbfc_top_asserts (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sleep_select_low_n_i,
  input wire logic motor_supply_low_i,
  input wire logic logic_supply_low_i,
  input wire logic thermal_trip_i,
  input wire logic fault_oe_o,
  input wire logic [1:0] bridge_leg_hi_o,
  input wire logic [1:0] bridge_leg_lo_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Pins need two sync stages, a state edge and a gate edge: five samples
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  no_shoot_a: assert property (!(|(bridge_leg_hi_o & bridge_leg_lo_o)))
    else $error("upper and lower gate on together");
  dead_upper_a: assert property ($fell(bridge_leg_hi_o[0]) |-> !bridge_leg_lo_o[0] [*8])
    else $error("leg A lower gate on without dead time");
  dead_lower_a: assert property ($fell(bridge_leg_lo_o[1]) |-> !bridge_leg_hi_o[1] [*8])
    else $error("leg B upper gate on without dead time");
  apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  error_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  standby_off_a: assert property (!sleep_select_low_n_i [*5] |->
    !fault_oe_o && bridge_leg_hi_o == 2'h0 && bridge_leg_lo_o == 2'h0)
    else $error("drive in standby");
  released_idle_a: assert property (!fault_oe_o |->
    bridge_leg_hi_o == 2'h0 && bridge_leg_lo_o == 2'h0)
    else $error("legs driven while fault pin released");
  thermal_off_a: assert property (thermal_trip_i [*5] |-> !fault_oe_o)
    else $error("running while hot");
  supply_off_a: assert property ((motor_supply_low_i || logic_supply_low_i) [*5] |-> !fault_oe_o)
    else $error("running in undervoltage");
endmodule : hbfc_top_asserts

bind hbfc_top hbfc_top_asserts u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_select_low_n_i(sleep_select_low_n_i),
  .motor_supply_low_i(motor_supply_low_i), .logic_supply_low_i(logic_supply_low_i),
  .thermal_trip_i(thermal_trip_i), .fault_oe_o(fault_oe_o),
  .bridge_leg_hi_o(bridge_leg_hi_o), .bridge_leg_lo_o(bridge_leg_lo_o));

// File: tb_hbridge_fault_and_chopper_ctrl.sv
/*
  Self-checking bench for hbfc_top: registers, decode, faults, chopper.
  Assumes the motor model and the checker bound to the top.
*/
`timescale 1ns/100ps
module tb_hbridge_fault_and_chopper_ctrl;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic sleep_n = 1'b1;
  logic sel_a = 1'b0;
  logic sel_b = 1'b0;
  logic mot_low = 1'b0;
  logic log_low = 1'b0;
  logic hot = 1'b0;
  logic [3:0] oc = 4'h0;
  logic stop_gnd = 1'b0;
  logic force_over = 1'b0;
  logic sense, fpin, pready, pslverr, fault_d, fault_oe;
  logic [31:0] prdata;
  logic [1:0] hi, lo;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam int DC = hbfc_pkg::DISCHARGE_CYCLES;
  localparam int DT = hbfc_pkg::DEAD_CYCLES;
  localparam logic [3:0] FWD = 4'h6;

  // ----------------------------------------------------------------
  // Plumbing
  // ----------------------------------------------------------------
  // Short stop and detect counts keep each fault scenario brief
  hbfc_top #(.STOP_CYCLES_RST(24'h00_0032), .DETECT_CYCLES_RST(24'h00_0004)) u_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sleep_select_low_n_i(sleep_n), .drive_select_a_i(sel_a),
    .drive_select_b_i(sel_b), .motor_supply_low_i(mot_low), .logic_supply_low_i(log_low),
    .thermal_trip_i(hot), .overcurrent_i(oc), .stop_pin_grounded_i(stop_gnd),
    .sense_voltage_over_i(sense), .fault_pin_i(fpin), .fault_o(fault_d),
    .fault_oe_o(fault_oe), .bridge_leg_hi_o(hi), .bridge_leg_lo_o(lo));
  hbfc_motor_model #(.LIMIT(200), .STEP(4)) u_motor (
    .clk_i(clk), .rst_n_i(rst_n), .leg_hi_i(hi), .leg_lo_i(lo), .fault_oe_i(fault_oe),
    .force_over_i(force_over), .sense_over_o(sense), .fault_pin_o(fpin));

  // Clock and hang guard
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Holds the request until ready is seen at an edge, then releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(n < 20, 1'b1, "apb answer");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic st(input logic [2:0] ex, input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, hbfc_pkg::ADDR_STATUS, 32'h0000_0000, r, e);
    chk(r[2:0], ex, m);
  endtask : st

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] ad[5] = '{hbfc_pkg::ADDR_CTRL, hbfc_pkg::ADDR_STOP, hbfc_pkg::ADDR_DETECT,
                          hbfc_pkg::ADDR_DEAD, 8'h14};
    logic [31:0] ex[5] = '{32'(hbfc_pkg::CTRL_CHOP_EN_RST), 32'h0000_0032, 32'h0000_0004,
                           32'(hbfc_pkg::DEAD_RST), 32'h0000_0000};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad[i], 32'h0000_0000, r, e);
      chk(r, ex[i], "reset value");
      chk(e, i == 4, "slave error");
    end
    apb(1'b1, hbfc_pkg::ADDR_STATUS, 32'hFFFF_FFFF, r, e);
    chk(e, 1'b0, "status write no error");
    st(3'h1, "status after write");
    apb(1'b1, hbfc_pkg::ADDR_STOP, 32'hFF00_0033, r, e);
    apb(1'b0, hbfc_pkg::ADDR_STOP, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0033, "stop count write");
    apb(1'b1, hbfc_pkg::ADDR_STOP, 32'h0000_0032, r, e);
    apb(1'b1, hbfc_pkg::ADDR_CTRL, 32'h0000_0000, r, e);
    $display("registers done");
  endtask : t_regs

  // Direct changes between modes, no idle gap between them
  task automatic t_decode();
    logic [1:0] s[5] = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h0};
    logic [3:0] ex[5] = '{4'h3, 4'h6, 4'h9, 4'h3, 4'h0};
    for (int i = 0; i < 5; i++) begin
      sel_a <= s[i][1];
      sel_b <= s[i][0];
      repeat (DT + 20) @(posedge clk);
      chk({hi, lo}, ex[i], "leg decode");
    end
    sel_a <= 1'b1;
    repeat (DT + 20) @(posedge clk);
    chk({fault_oe, fpin, fault_d}, 3'h4, "fault pin low in run");
    $display("decode done");
  endtask : t_decode

  task automatic t_uv();
    for (int i = 0; i < 2; i++) begin
      mot_low <= (i == 0);
      log_low <= (i == 1);
      repeat (10) @(posedge clk);
      chk({fault_oe, hi, lo}, 5'h00, "off in undervoltage");
      st(3'h2, "undervoltage state");
      mot_low <= 1'b0;
      log_low <= 1'b0;
      repeat (DT + 20) @(posedge clk);
      chk({hi, lo}, FWD, "drive resumes");
    end
    $display("undervoltage done");
  endtask : t_uv

  // Kind 0 is the thermal trip, kind 1 overcurrent; latch grounds the stop pin
  task automatic t_fault(input int kind, input logic latch);
    stop_gnd <= latch;
    if (kind == 1) begin
      oc <= 4'h1;
      repeat (2) @(posedge clk);
      oc <= 4'h0;
      repeat (10) @(posedge clk);
      chk(fault_oe, 1'b1, "short overcurrent ignored");
      oc <= latch ? 4'h8 : 4'h4;
    end else
      hot <= 1'b1;
    repeat (16) @(posedge clk);
    chk({fault_oe, hi, lo}, 5'h00, "off on trip");
    st(kind == 0 ? 3'h3 : 3'h4, "trip state");
    if (kind == 0) begin
      repeat (100) @(posedge clk);
      chk({fault_oe, hi, lo}, 5'h00, "hot holds off");
    end
    hot <= 1'b0;
    oc <= 4'h0;
    repeat (20) @(posedge clk);
    if (kind == 1)
      chk({fault_oe, hi, lo}, 5'h00, "stop interval running");
    repeat (80) @(posedge clk);
    if (latch) begin
      chk({fault_oe, hi, lo}, 5'h00, "trip latched");
      sleep_n <= 1'b0;
      repeat (10) @(posedge clk);
      st(3'h0, "standby state");
      sleep_n <= 1'b1;
      repeat (DT + 20) @(posedge clk);
    end
    chk({fault_oe, hi, lo}, {1'b1, FWD}, "drive resumes");
    stop_gnd <= 1'b0;
    $display("fault %0d latch %0d done", kind, latch);
  endtask : t_fault

  // Time leg A upper gate on, then off; sense is released at off count rel
  task automatic meas(input int rel, output int off_n, output int on_n);
    off_n = 0;
    on_n = 0;
    while (hi[0] !== 1'b0 && on_n < 3000) begin
      @(posedge clk);
      on_n++;
    end
    while (hi[0] === 1'b0 && off_n < 3000) begin
      @(posedge clk);
      off_n++;
      if (off_n == 100)
        chk({hi, lo}, 4'h3, "brake in discharge");
      if (off_n == rel)
        force_over <= 1'b0;
    end
  endtask : meas

  task automatic t_chop();
    int off_n, on_n;
    logic [31:0] r;
    logic e;
    apb(1'b1, hbfc_pkg::ADDR_CTRL, 32'h0000_0001, r, e);
    meas(0, off_n, on_n);
    chk(off_n >= DC && off_n <= DC + DT + 4, 1'b1, "discharge length");
    force_over <= 1'b1;
    meas(400, off_n, on_n);
    chk(on_n >= hbfc_pkg::MIN_CHARGE_CYCLES - DT - 2, 1'b1, "minimum charge");
    chk(off_n >= 2 * DC && off_n <= 2 * DC + DT + 4, 1'b1, "repeat discharge");
    $display("chopper done");
  endtask : t_chop

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_decode();
    t_uv();
    t_fault(0, 1'b0);
    t_fault(0, 1'b1);
    t_fault(1, 1'b0);
    t_fault(1, 1'b1);
    t_chop();
    stop_test();
  end
endmodule : tb_hbridge_fault_and_chopper_ctrl
